// ===== rtl/palette_shifter_defines.svh
// Constants for the planar palette shifter
`ifndef PALETTE_SHIFTER_DEFINES_SVH
`define PALETTE_SHIFTER_DEFINES_SVH
`define BUS_W 32
`define ADDR_W 8
`define WORD_W 16
`define LVL_W 3
`define COL_W 9
`define PAL_ENTRIES 16
`define PLANE_MAX 4
`define FIFO_DEPTH 8
`define CTRL_ADDR 8'h40
`define STAT_ADDR 8'h44
`define PAL_SEL_FIELD 7:6
`define PAL_IDX_FIELD 5:2
`define REG_IDX_FIELD 7:2
`define MODE_FIELD 1:0
`define RED_FIELD 8:6
`define GRN_FIELD 5:3
`define BLU_FIELD 2:0
`define INVERT_BIT 0
`define PIX_PER_WORD 5'h10
`define PLANES_LOW 3'h4
`define PLANES_MED 3'h2
`define PLANES_MONO 3'h1
`endif

// ===== rtl/palette_shifter_pkg.sv
// Types for the planar palette shifter
`include "palette_shifter_defines.svh"
package palette_shifter_pkg;
   typedef enum logic [1:0] {
      MODE_LOW = 2'b00,
      MODE_MEDIUM = 2'b01,
      MODE_MONO = 2'b10
   } mode_type;
   typedef logic [`COL_W-1:0] colour_type;
   typedef struct packed {
      colour_type [`PAL_ENTRIES-1:0] palette;
      mode_type mode;
      logic [`PLANE_MAX-1:0][`WORD_W-1:0] plane;
      logic [2:0] group_count;
      logic [`PLANE_MAX-1:0][`WORD_W-1:0] shift;
      logic [4:0] remain;
      logic wr_pending;
      logic [`ADDR_W-1:0] wr_addr;
      logic [`BUS_W-1:0] hrdata;
      logic okay_ready;
      logic hresp;
      logic [`LVL_W-1:0] red;
      logic [`LVL_W-1:0] green;
      logic [`LVL_W-1:0] blue;
      logic mono;
      logic pixel_valid;
      logic hsync;
      logic vsync;
   } top_state_type;
endpackage : palette_shifter_pkg

// ===== rtl/planar_video_palette_shifter.sv
// Planar video shifter with palette, word FIFO and AHB-Lite registers
// What this block does
// - Sixteen entries; medium four; mono uses entry0 bit0
// - Each entry holds eight-level red, green, blue
// - Three on/off lines per colour
// - Monochrome bypasses palette on own output
// - Memory seen as 1, 2 or 4 planes
// - One 16-bit word per transfer, serialised
// - One word per plane in use (4, 2 or 1) per 16 pixels, bit 0 first
// - Plane bits index equal-numbered palette entry
// - Words loaded while line active
// - Blanking forces video outputs off
// - Word strobe latches display word
`timescale 1ns/1ps
`include "palette_shifter_defines.svh"
`default_nettype none

module palette_word_fifo #(
   parameter int WIDTH = `WORD_W,
   parameter int DEPTH = `FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [$clog2(DEPTH+1)-1:0] count
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] rd;
      logic [AW-1:0] wr;
      logic [CW-1:0] count;
      logic full;
   } fifo_state_type;
   fifo_state_type s;
   fifo_state_type next_s;
   logic push;
   logic pop;

   assign in_ready = !s.full;
   assign out_valid = s.count != '0;
   assign out_data = s.mem[s.rd];
   assign count = s.count;

   always_comb begin
      next_s = s;
      push = in_valid && !s.full;
      pop = out_valid && out_ready;
      if (push) begin
         next_s.mem[s.wr] = in_data;
         next_s.wr = AW'(s.wr + 1'b1);
      end
      if (pop) begin
         next_s.rd = AW'(s.rd + 1'b1);
      end
      if (push && !pop) begin
         next_s.count = CW'(s.count + 1'b1);
      end else if (pop && !push) begin
         next_s.count = CW'(s.count - 1'b1);
      end
      next_s.full = next_s.count == CW'(DEPTH);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   a_fifo_bounded: assert property (@(posedge clk) disable iff (!rst_n)
      (s.full |-> s.count == CW'(DEPTH)) and (push && !pop |=> s.count == $past(s.count) + 1'b1))
      else $error("FIFO count wrong");
endmodule : palette_word_fifo

module planar_video_palette_shifter #(
   parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
   // System
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [`BUS_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [`BUS_W-1:0] hwdata,
   output logic [`BUS_W-1:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Memory controller
   input wire logic display_word_strobe,
   input wire logic [`WORD_W-1:0] display_word,
   output logic display_word_ready,
   input wire logic palette_write_select,
   // Timing logic
   input wire logic line_active,
   input wire logic blank,
   input wire logic hsync_in,
   input wire logic vsync_in,
   input wire logic mono_monitor_sense,
   // Video outputs
   output logic [`LVL_W-1:0] red,
   output logic [`LVL_W-1:0] green,
   output logic [`LVL_W-1:0] blue,
   output logic mono_video,
   output logic pixel_valid,
   output logic hsync_out,
   output logic vsync_out
);
   localparam int CW = $clog2(FIFO_DEPTH+1);
   palette_shifter_pkg::top_state_type s;
   palette_shifter_pkg::top_state_type next_s;
   logic fifo_valid;
   logic fifo_ready;
   logic [`WORD_W-1:0] fifo_data;
   logic [CW-1:0] fifo_count;
   logic [2:0] planes;
   logic [3:0] pix_index;
   logic addr_phase;
   logic mapped;
   palette_shifter_pkg::colour_type colour;

   // Words enter only on a strobe inside an active line
   palette_word_fifo #(
      .WIDTH(`WORD_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(hclk),
      .rst_n(hresetn),
      .in_valid(display_word_strobe && line_active),
      .in_ready(display_word_ready),
      .in_data(display_word),
      .out_valid(fifo_valid),
      .out_ready(fifo_ready),
      .out_data(fifo_data),
      .count(fifo_count)
   );

   always_comb begin
      next_s = s;
      unique case (s.mode)
         palette_shifter_pkg::MODE_LOW: planes = `PLANES_LOW;
         palette_shifter_pkg::MODE_MEDIUM: planes = `PLANES_MED;
         palette_shifter_pkg::MODE_MONO: planes = `PLANES_MONO;
         default: planes = `PLANES_LOW;
      endcase
      fifo_ready = s.group_count < planes;
      addr_phase = hsel && htrans[1] && hready;
      mapped = haddr[`BUS_W-1:`ADDR_W] == '0;

      // Register write data phase
      if (s.wr_pending) begin
         if (s.wr_addr[`PAL_SEL_FIELD] == 2'h0 && palette_write_select) begin
            next_s.palette[s.wr_addr[`PAL_IDX_FIELD]] = hwdata[`COL_W-1:0];
         end
         if (s.wr_addr[`REG_IDX_FIELD] == `CTRL_ADDR >> 2 && hwdata[`MODE_FIELD] != 2'h3) begin
            next_s.mode = palette_shifter_pkg::mode_type'(hwdata[`MODE_FIELD]);
         end
      end
      next_s.wr_pending = addr_phase && hwrite && mapped;
      if (addr_phase) begin
         next_s.wr_addr = haddr[`ADDR_W-1:0];
      end

      // Plane words gathered in order plane 0 upward
      if (fifo_valid && fifo_ready) begin
         next_s.plane[s.group_count[1:0]] = fifo_data;
         next_s.group_count = 3'(s.group_count + 1'b1);
      end

      // Pixel index from bit 0 of each plane in use; mono index is 0
      unique case (s.mode)
         palette_shifter_pkg::MODE_LOW:
            pix_index = {s.shift[3][0], s.shift[2][0], s.shift[1][0], s.shift[0][0]};
         palette_shifter_pkg::MODE_MEDIUM:
            pix_index = {2'h0, s.shift[1][0], s.shift[0][0]};
         palette_shifter_pkg::MODE_MONO:
            pix_index = 4'h0;
         default:
            pix_index = 4'h0;
      endcase
      colour = s.palette[pix_index];

      next_s.red = '0;
      next_s.green = '0;
      next_s.blue = '0;
      next_s.mono = 1'b0;
      next_s.pixel_valid = 1'b0;
      if (s.remain != 5'h0) begin
         if (s.mode == palette_shifter_pkg::MODE_MONO) begin
            next_s.mono = s.shift[0][0] ^ s.palette[0][`INVERT_BIT];
         end else begin
            next_s.red = colour[`RED_FIELD];
            next_s.green = colour[`GRN_FIELD];
            next_s.blue = colour[`BLU_FIELD];
         end
         next_s.pixel_valid = 1'b1;
         for (int k = 0; k < `PLANE_MAX; k++) begin
            next_s.shift[k] = s.shift[k] >> 1;
         end
         next_s.remain = 5'(s.remain - 1'b1);
      end else if (s.group_count >= planes) begin
         next_s.shift = s.plane;
         next_s.remain = `PIX_PER_WORD;
         next_s.group_count = 3'h0;
      end
      if (blank) begin
         next_s.red = '0;
         next_s.green = '0;
         next_s.blue = '0;
         next_s.mono = 1'b0;
         next_s.pixel_valid = 1'b0;
      end
      next_s.hsync = hsync_in;
      next_s.vsync = vsync_in;

      // Read data sees writes of the same edge
      if (addr_phase && !hwrite) begin
         next_s.hrdata = '0;
         if (mapped && haddr[`PAL_SEL_FIELD] == 2'h0) begin
            next_s.hrdata = `BUS_W'(next_s.palette[haddr[`PAL_IDX_FIELD]]);
         end else if (mapped && haddr[`REG_IDX_FIELD] == `CTRL_ADDR >> 2) begin
            next_s.hrdata = `BUS_W'(next_s.mode);
         end else if (mapped && haddr[`REG_IDX_FIELD] == `STAT_ADDR >> 2) begin
            next_s.hrdata = `BUS_W'({fifo_count, s.remain != 5'h0, line_active, mono_monitor_sense});
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '0;
         s.okay_ready <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign hrdata = s.hrdata;
   assign hreadyout = s.okay_ready;
   assign hresp = s.hresp;
   assign red = s.red;
   assign green = s.green;
   assign blue = s.blue;
   assign mono_video = s.mono;
   assign pixel_valid = s.pixel_valid;
   assign hsync_out = s.hsync;
   assign vsync_out = s.vsync;

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   a_blank_dark: assert property (
      blank |=> red == '0 && green == '0 && blue == '0 && !mono_video && !pixel_valid)
      else $error("Video not dark during blanking");
   a_pal_guard: assert property (
      s.wr_pending && !palette_write_select |=> $stable(s.palette))
      else $error("Palette changed without select");
   a_pal_store: assert property (
      s.wr_pending && palette_write_select && s.wr_addr[`PAL_SEL_FIELD] == 2'h0
      |=> s.palette[$past(s.wr_addr[`PAL_IDX_FIELD])] == $past(hwdata[`COL_W-1:0]))
      else $error("Palette entry not stored");
   a_group_load: assert property (
      s.remain == 5'h0 && s.group_count >= planes
      |=> s.remain == `PIX_PER_WORD && s.group_count == 3'h0 && s.shift == $past(s.plane))
      else $error("Plane group not loaded");
   a_pixel_step: assert property (
      s.remain != 5'h0 |=> s.remain == $past(s.remain) - 5'h1)
      else $error("Shifter skipped a pixel");
   a_index_colour: assert property (
      s.remain != 5'h0 && !blank && s.mode != palette_shifter_pkg::MODE_MONO
      |=> {red, green, blue} == $past(s.palette[pix_index]) && pixel_valid)
      else $error("Pixel colour not from indexed entry");
   a_mono_bypass: assert property (
      s.remain != 5'h0 && !blank && s.mode == palette_shifter_pkg::MODE_MONO
      |=> mono_video == $past(s.shift[0][0] ^ s.palette[0][`INVERT_BIT]) && red == '0)
      else $error("Monochrome output wrong");
   a_medium_range: assert property (
      s.mode == palette_shifter_pkg::MODE_MEDIUM && s.remain != 5'h0 && !blank
      |=> {red, green, blue} == $past(s.palette[{2'h0, s.shift[1][0], s.shift[0][0]}]))
      else $error("Medium index beyond four entries");
endmodule : planar_video_palette_shifter

`default_nettype wire

// ===== tb/display_feeder.sv
// Memory controller model feeding display words
`timescale 1ns/1ps
`default_nettype none
module display_feeder (
   // Clock
   input wire logic clk,
   // Timing logic
   input wire logic vsync,
   // Shifter side
   input wire logic ready,
   output logic strobe,
   output logic [15:0] word,
   output logic active
);
   int stalls = 0;
   // Frame start sits on a 256-byte boundary
   localparam logic [23:0] FRAME_BASE = 24'h07_8000;
   logic [23:0] fetch_addr = FRAME_BASE;
   // Fetch address restarts from the frame base on vertical sync
   always @(posedge clk) begin
      if (vsync) begin
         fetch_addr <= FRAME_BASE;
      end else if (strobe && ready && active) begin
         fetch_addr <= fetch_addr + 24'h2;
      end
   end
   initial begin
      strobe = 1'b0;
      word = 16'hFFFF;
      active = 1'b0;
   end
   // Plane words in order, held until taken
   task automatic send(input logic [63:0] w, input int n, input int gap);
      for (int i = 0; i < n; i++) begin
         active <= 1'b1;
         strobe <= 1'b1;
         word <= w[16 * (i % 4) +: 16];
         @(posedge clk);
         while (ready !== 1'b1) begin
            stalls++;
            @(posedge clk);
         end
         if (gap > 0 || i == n - 1) begin
            strobe <= 1'b0;
            word <= ~w[16 * (i % 4) +: 16];
            repeat (gap) @(posedge clk);
         end
      end
      active <= 1'b0;
   endtask : send
endmodule : display_feeder
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the planar palette shifter
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic hclk, hresetn, hwrite, pal_sel, blank, hs, vs, sense;
   logic hreadyout, hresp, dstrobe, dready, lactive, mono_video, pixel_valid, hsync_out, vsync_out;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata;
   logic [15:0] dword;
   logic [2:0] red, green, blue;
   logic [63:0] pat = 64'h00FF_3355_F00F_5A3C;
   int n_mismatch = 0;
   int checks_done = 0;
   // Timing logic frame rate setting, high for 60 Hz
   logic rate_60 = 1'b1;
   planar_video_palette_shifter u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .display_word_strobe(dstrobe),
      .display_word(dword), .display_word_ready(dready), .palette_write_select(pal_sel),
      .line_active(lactive), .blank(blank), .hsync_in(hs), .vsync_in(vs), .mono_monitor_sense(sense),
      .red(red), .green(green), .blue(blue), .mono_video(mono_video), .pixel_valid(pixel_valid),
      .hsync_out(hsync_out), .vsync_out(vsync_out));
   display_feeder u_feed (.clk(hclk), .vsync(vs), .ready(dready), .strobe(dstrobe), .word(dword),
      .active(lactive));
   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end
   function automatic logic [8:0] col(input int n);
      return 9'((n * 37 + 5) % 512);
   endfunction : col
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask : xfer
   task automatic test_regs();
      logic [31:0] d;
      xfer(1'b0, 32'h0C, 32'h0, d);
      chk("palette reset", 32'h0, d);
      pal_sel <= 1'b1;
      for (int n = 0; n < 16; n++) xfer(1'b1, 32'(4 * n), 32'(col(n)), d);
      xfer(1'b1, 32'h104, 32'h1FF, d);
      xfer(1'b0, 32'h04, 32'h0, d);
      chk("unmapped write", 32'(col(1)), d);
      xfer(1'b0, 32'h14, 32'h0, d);
      chk("palette 5", 32'(col(5)), d);
      pal_sel <= 1'b0;
      xfer(1'b1, 32'h14, 32'h1FF, d);
      xfer(1'b0, 32'h14, 32'h0, d);
      chk("palette guarded", 32'(col(5)), d);
      xfer(1'b0, 32'h100, 32'h0, d);
      chk("unmapped", 32'h0, d);
      xfer(1'b1, 32'h40, 32'h1, d);
      xfer(1'b1, 32'h40, 32'h3, d);
      xfer(1'b0, 32'h40, 32'h0, d);
      chk("mode 3 refused", 32'h1, d);
      chk("okay response", 32'h2, 32'({hreadyout, hresp}));
      sense <= 1'b0;
      xfer(1'b0, 32'h44, 32'h0, d);
      chk("sense low", 32'h0, d & 32'h1);
      sense <= 1'b1;
      xfer(1'b0, 32'h44, 32'h0, d);
      chk("sense high", 32'h1, d & 32'h1);
      $display("test regs done");
   endtask : test_regs
   task automatic test_modes();
      logic [31:0] d;
      logic [3:0] idx;
      logic [8:0] pinv;
      int k;
      pinv = col(0);
      for (int m = 0; m < 3; m++) begin
         xfer(1'b1, 32'h40, 32'(m), d);
         u_feed.send(pat, 4 >> m, m);
         k = 0;
         while (pixel_valid !== 1'b1 && k < 60) begin
            @(posedge hclk);
            k++;
         end
         for (int b = 0; b < 16; b++) begin
            idx = {pat[48 + b] & (m == 0), pat[32 + b] & (m == 0), pat[16 + b] & (m < 2), pat[b]};
            chk("pixel", 32'({1'b1, (m == 2) ? 9'h0 : col(idx), (m == 2) & (pat[b] ^ pinv[0])}),
               32'({pixel_valid, red, green, blue, mono_video}));
            @(posedge hclk);
         end
      end
      $display("test modes done");
   endtask : test_modes
   task automatic test_fill();
      logic [31:0] d;
      int k;
      k = 0;
      fork
         u_feed.send(pat, 12, 0);
         repeat (260) begin
            @(posedge hclk);
            if (pixel_valid === 1'b1) k++;
         end
      join
      chk("stalled", 32'h1, 32'(u_feed.stalls > 0));
      chk("pixel count", 32'd192, 32'(k));
      xfer(1'b0, 32'h44, 32'h0, d);
      chk("fifo empty", 32'h0, 32'(d[6:3]));
      $display("test fill done");
   endtask : test_fill
   task automatic test_blank();
      int span;
      span = rate_60 ? 30 : 36;
      blank <= 1'b1;
      u_feed.send(pat, 1, 0);
      repeat (span) begin
         @(posedge hclk);
         chk("blanked", 32'h0, 32'({pixel_valid, red, green, blue, mono_video}));
      end
      blank <= 1'b0;
      hs <= 1'b1;
      vs <= 1'b1;
      @(posedge hclk);
      chk("sync early", 32'h0, 32'({hsync_out, vsync_out}));
      @(posedge hclk);
      chk("sync", 32'h3, 32'({hsync_out, vsync_out}));
      chk("frame reload", 32'(u_feed.FRAME_BASE), 32'(u_feed.fetch_addr));
      $display("test blank done");
   endtask : test_blank
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : test_done
   initial begin
      repeat (3000) @(posedge hclk);
      n_mismatch++;
      test_done();
   end
   initial begin
      hresetn = 1'b0;
      htrans = 2'h0;
      haddr = 32'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      pal_sel = 1'b0;
      blank = 1'b0;
      hs = 1'b0;
      vs = 1'b0;
      sense = 1'b1;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      test_regs();
      test_modes();
      test_fill();
      test_blank();
      test_done();
   end
endmodule : testbench
`default_nettype wire
